// *** logic/param_bank_params.svh ***
`ifndef PARAM_BANK_PARAMS_SVH
`define PARAM_BANK_PARAMS_SVH

// ****************************************
// Offsets
// ****************************************
`define OFS_BUS_ADDR    5'h00
`define OFS_CHAN_LIST   5'h01
`define OFS_PROX12_EMIT 5'h02
`define OFS_PROX3_EMIT  5'h03
`define OFS_ALIGN       5'h05
`define OFS_HISTORY     5'h19
`define OFS_OFFSET      5'h1a
`define OFS_RSVD_1B     5'h1b
`define OFS_EMIT_REC    5'h1c
`define OFS_IR_COUNT    5'h1d
`define OFS_IR_GAIN     5'h1e
`define OFS_IR_MISC     5'h1f
`define PARAM_DEPTH     32
`define PARAM_TOP       8'h1f

// ****************************************
// Writable bit masks
// ****************************************
`define MASK_FULL       8'hff
`define MASK_CHAN_LIST  8'h77
`define MASK_PROX12     8'h77
`define MASK_PROX3      8'h07
`define MASK_ALIGN      8'h70
`define MASK_IR_COUNT   8'h70
`define MASK_IR_GAIN    8'h07
`define MASK_IR_MISC    8'h20
`define MASK_NONE       8'h00

// ****************************************
// Reset values
// ****************************************
`define RST_ZERO        8'h00
`define RST_PROX12      8'h21
`define RST_PROX3       8'h04
// Arbitrary power-up bus address
`define DEFAULT_BUS_ADDR 8'h10

// ****************************************
// Field positions
// ****************************************
`define BIT_ON_PS1      0
`define BIT_ON_PS2      1
`define BIT_ON_PS3      2
`define BIT_EN_VIS      4
`define BIT_EN_IR       5
`define BIT_EN_AUX      6
`define PS1_EMIT_LSB    0
`define PS2_EMIT_LSB    4
`define PS3_EMIT_LSB    0
`define EMIT_W          3
`define BIT_PS1_LOW     4
`define BIT_PS2_LOW     5
`define BIT_PS3_LOW     6
`define NUM_CHAN        6

`endif

// *** logic/param_bank_pkg.sv ***
package param_bank_pkg;
  typedef logic [15:0] result_t;
  typedef logic [7:0]  param_t;
  typedef enum logic [2:0] {
    CH_PS1,
    CH_PS2,
    CH_PS3,
    CH_VIS,
    CH_IR,
    CH_AUX
  } chan_e;
endpackage

// *** logic/result_if.sv ***
`timescale 1ns/1ps
interface result_if;
  import param_bank_pkg::*;
  logic                 store;
  chan_e                slot;
  logic [16:0]          raw;
  logic                 low;
  logic [5:0][15:0]     results;
  modport feeder (
    output store,
    output slot,
    output raw,
    output low,
    input  results
  );
  modport keeper (
    input  store,
    input  slot,
    input  raw,
    input  low,
    output results
  );
endinterface

// *** logic/result_store.sv ***
`timescale 1ns/1ps
`include "param_bank_params.svh"
module result_store (
  // Clock and reset
  input  wire logic      i_mclk,
  input  wire logic      i_srst,
  // Conversion side
  result_if.keeper       rif
);
  import param_bank_pkg::*;

  // ****************************************
  // Result pairs
  // ****************************************
  logic [5:0][15:0] res_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      res_q <= '0;
    end else if (rif.store) begin
      // Low or upper 16 of the 17-bit word
      res_q[rif.slot] <= rif.low ? rif.raw[15:0] : rif.raw[16:1];
    end
  end

  assign rif.results = res_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  a_store_aux: assert property (
    rif.store && rif.slot == CH_AUX
    |=> res_q[CH_AUX] == $past(rif.raw[16:1])
  ) else $error("aux result not stored");

  a_store_ir: assert property (
    rif.store && rif.slot == CH_IR
    |=> res_q[CH_IR] == $past(rif.raw[16:1])
  ) else $error("ir result not stored");

  a_store_vis: assert property (
    rif.store && rif.slot == CH_VIS
    |=> res_q[CH_VIS] == $past(rif.raw[16:1])
  ) else $error("visible result not stored");

  a_idle_hold: assert property (
    !rif.store |=> $stable(res_q)
  ) else $error("result changed without store");
endmodule

// *** logic/param_bank.sv ***
`timescale 1ns/1ps
`include "param_bank_params.svh"
module param_bank (
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  // Parameter write command
  input  wire logic                  i_wr_req,
  input  wire logic [7:0]            i_wr_offset,
  input  wire param_bank_pkg::param_t i_wr_data,
  // Parameter read command
  input  wire logic                  i_rd_req,
  input  wire logic [7:0]            i_rd_offset,
  output logic                       o_rd_valid,
  output param_bank_pkg::param_t     o_rd_data,
  // Bus address
  input  wire logic                  i_addr_commit,
  output param_bank_pkg::param_t     o_bus_addr,
  // Measurement sequencer
  input  wire logic                  i_meas_active,
  input  wire param_bank_pkg::chan_e i_meas_chan,
  output logic [2:0]                 o_emitter_drive,
  output param_bank_pkg::param_t     o_chan_list,
  output logic                       o_list_empty,
  // Conversion results
  input  wire logic                  i_conv_valid,
  input  wire param_bank_pkg::chan_e i_conv_chan,
  input  wire logic [16:0]           i_conv_data,
  output logic [5:0][15:0]           o_result,
  // Other ambient settings
  output param_bank_pkg::param_t     o_history,
  output param_bank_pkg::param_t     o_adc_offset,
  output param_bank_pkg::param_t     o_emit_rec,
  output param_bank_pkg::param_t     o_ir_count,
  output param_bank_pkg::param_t     o_ir_gain,
  output param_bank_pkg::param_t     o_ir_misc
);
  import param_bank_pkg::*;

  // ****************************************
  // Functions
  // ****************************************
  function automatic param_t wr_mask(input logic [4:0] ofs);
    case (ofs)
      `OFS_BUS_ADDR:    wr_mask = `MASK_FULL;
      `OFS_CHAN_LIST:   wr_mask = `MASK_CHAN_LIST;
      `OFS_PROX12_EMIT: wr_mask = `MASK_PROX12;
      `OFS_PROX3_EMIT:  wr_mask = `MASK_PROX3;
      `OFS_ALIGN:       wr_mask = `MASK_ALIGN;
      `OFS_HISTORY:     wr_mask = `MASK_FULL;
      `OFS_OFFSET:      wr_mask = `MASK_FULL;
      `OFS_EMIT_REC:    wr_mask = `MASK_FULL;
      `OFS_IR_COUNT:    wr_mask = `MASK_IR_COUNT;
      `OFS_IR_GAIN:     wr_mask = `MASK_IR_GAIN;
      `OFS_IR_MISC:     wr_mask = `MASK_IR_MISC;
      default:          wr_mask = `MASK_NONE;
    endcase
  endfunction

  function automatic param_t rst_val(input logic [4:0] ofs);
    case (ofs)
      `OFS_PROX12_EMIT: rst_val = `RST_PROX12;
      `OFS_PROX3_EMIT:  rst_val = `RST_PROX3;
      default:          rst_val = `RST_ZERO;
    endcase
  endfunction

  // Offsets above the table are outside the bank
  function automatic param_t eff_mask(input logic [7:0] ofs);
    eff_mask = (ofs > `PARAM_TOP) ? `MASK_NONE : wr_mask(ofs[4:0]);
  endfunction

  function automatic logic chan_on(input chan_e c, input param_t l);
    case (c)
      CH_PS1:  chan_on = l[`BIT_ON_PS1];
      CH_PS2:  chan_on = l[`BIT_ON_PS2];
      CH_PS3:  chan_on = l[`BIT_ON_PS3];
      CH_VIS:  chan_on = l[`BIT_EN_VIS];
      CH_IR:   chan_on = l[`BIT_EN_IR];
      CH_AUX:  chan_on = l[`BIT_EN_AUX];
      default: chan_on = 1'b0;
    endcase
  endfunction

  function automatic logic [2:0] emit_of(input chan_e c,
                                         input param_t p12,
                                         input param_t p3);
    case (c)
      CH_PS1:  emit_of = p12[`PS1_EMIT_LSB +: `EMIT_W];
      CH_PS2:  emit_of = p12[`PS2_EMIT_LSB +: `EMIT_W];
      CH_PS3:  emit_of = p3[`PS3_EMIT_LSB +: `EMIT_W];
      default: emit_of = 3'h0;
    endcase
  endfunction

  function automatic logic low_of(input chan_e c, input param_t a);
    case (c)
      CH_PS1:  low_of = a[`BIT_PS1_LOW];
      CH_PS2:  low_of = a[`BIT_PS2_LOW];
      CH_PS3:  low_of = a[`BIT_PS3_LOW];
      default: low_of = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Parameter memory
  // ****************************************
  // Only reachable through the command port, never by bus address
  param_t param_q [0:`PARAM_DEPTH-1];
  logic   wr_hit;

  assign wr_hit = i_wr_req && (i_wr_offset <= `PARAM_TOP);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int k = 0; k < `PARAM_DEPTH; k++) begin
        param_q[k] <= rst_val(5'(k));
      end
    end else if (wr_hit) begin
      // Reserved bits dropped on the way
      param_q[i_wr_offset[4:0]] <=
        i_wr_data & wr_mask(i_wr_offset[4:0]);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  param_t rd_data_q;
  logic   rd_valid_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= `RST_ZERO;
    end else begin
      rd_valid_q <= i_rd_req;
      if (i_rd_req) begin
        // Mask again so unmapped offsets read zero
        rd_data_q <= param_q[i_rd_offset[4:0]] & eff_mask(i_rd_offset);
      end
    end
  end

  assign o_rd_valid = rd_valid_q;
  assign o_rd_data  = rd_data_q;

  // ****************************************
  // Bus address
  // ****************************************
  // Host keeps the old address until commit, so no mid-frame switch
  param_t bus_addr_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bus_addr_q <= `DEFAULT_BUS_ADDR;
    end else if (i_addr_commit) begin
      bus_addr_q <= param_q[`OFS_BUS_ADDR];
    end
  end

  assign o_bus_addr = bus_addr_q;

  // ****************************************
  // Emitter drive
  // ****************************************
  logic [2:0] emit_q;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      emit_q <= 3'h0;
    end else if (i_meas_active) begin
      emit_q <= emit_of(i_meas_chan, param_q[`OFS_PROX12_EMIT],
                        param_q[`OFS_PROX3_EMIT]);
    end else begin
      emit_q <= 3'h0;
    end
  end

  assign o_emitter_drive = emit_q;

  // ****************************************
  // Channel list and conversions
  // ****************************************
  result_if rif ();

  // Disabled channels keep their last result
  assign rif.store = i_conv_valid &&
                     chan_on(i_conv_chan, param_q[`OFS_CHAN_LIST]);
  assign rif.slot  = i_conv_chan;
  assign rif.raw   = i_conv_data;
  assign rif.low   = low_of(i_conv_chan, param_q[`OFS_ALIGN]);

  result_store u_store (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .rif    (rif.keeper)
  );

  assign o_result     = rif.results;
  assign o_chan_list  = param_q[`OFS_CHAN_LIST];
  // Sequencer should refuse to start on an empty list
  assign o_list_empty = (param_q[`OFS_CHAN_LIST] == `RST_ZERO);
  assign o_history    = param_q[`OFS_HISTORY];
  assign o_adc_offset = param_q[`OFS_OFFSET];
  assign o_emit_rec   = param_q[`OFS_EMIT_REC];
  assign o_ir_count   = param_q[`OFS_IR_COUNT];
  assign o_ir_gain    = param_q[`OFS_IR_GAIN];
  assign o_ir_misc    = param_q[`OFS_IR_MISC];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_no_commit;
    !i_addr_commit;
  endsequence

  sequence s_commit;
    i_addr_commit;
  endsequence

  a_addr_hold: assert property (
    s_no_commit |=> bus_addr_q == $past(bus_addr_q)
  ) else $error("bus address moved without commit");

  a_addr_commit: assert property (
    s_commit |=> bus_addr_q == $past(param_q[`OFS_BUS_ADDR])
  ) else $error("commit did not load new address");

  a_emit_prox1: assert property (
    i_meas_active && i_meas_chan == CH_PS1
    |=> emit_q == $past(param_q[`OFS_PROX12_EMIT][2:0])
  ) else $error("prox1 emitter wrong");

  a_emit_prox2: assert property (
    i_meas_active && i_meas_chan == CH_PS2
    |=> emit_q == $past(param_q[`OFS_PROX12_EMIT][6:4])
  ) else $error("prox2 emitter wrong");

  a_emit_prox3: assert property (
    i_meas_active && i_meas_chan == CH_PS3
    |=> emit_q == $past(param_q[`OFS_PROX3_EMIT][2:0])
  ) else $error("prox3 emitter wrong");

  a_reset_emit: assert property (
    $past(i_srst) |-> param_q[`OFS_PROX12_EMIT] == `RST_PROX12 &&
                      param_q[`OFS_PROX3_EMIT] == `RST_PROX3
  ) else $error("emitter defaults wrong after reset");

  a_rsvd_zero: assert property (
    i_rd_req |=> rd_valid_q &&
      (rd_data_q & ~$past(eff_mask(i_rd_offset))) == `RST_ZERO
  ) else $error("reserved bits read nonzero");

  a_align_p1: assert property (
    i_conv_valid && i_conv_chan == CH_PS1 &&
    param_q[`OFS_CHAN_LIST][`BIT_ON_PS1]
    |=> o_result[CH_PS1] == ($past(param_q[`OFS_ALIGN][`BIT_PS1_LOW]) ?
          $past(i_conv_data[15:0]) : $past(i_conv_data[16:1]))
  ) else $error("prox1 alignment wrong");

  a_align_p2: assert property (
    i_conv_valid && i_conv_chan == CH_PS2 &&
    param_q[`OFS_CHAN_LIST][`BIT_ON_PS2]
    |=> o_result[CH_PS2] == ($past(param_q[`OFS_ALIGN][`BIT_PS2_LOW]) ?
          $past(i_conv_data[15:0]) : $past(i_conv_data[16:1]))
  ) else $error("prox2 alignment wrong");

  a_align_p3: assert property (
    i_conv_valid && i_conv_chan == CH_PS3 &&
    param_q[`OFS_CHAN_LIST][`BIT_ON_PS3]
    |=> o_result[CH_PS3] == ($past(param_q[`OFS_ALIGN][`BIT_PS3_LOW]) ?
          $past(i_conv_data[15:0]) : $past(i_conv_data[16:1]))
  ) else $error("prox3 alignment wrong");

  a_skip_off: assert property (
    i_conv_valid && !chan_on(i_conv_chan, param_q[`OFS_CHAN_LIST])
    |=> $stable(o_result)
  ) else $error("disabled channel result changed");
endmodule

// *** bench/host_model.sv ***
`timescale 1ns/1ps
module host_model
  import param_bank_pkg::*;
(
  // Clock
  input  wire logic                   i_mclk,
  // Read answer
  input  wire logic                   i_rd_valid,
  input  wire param_bank_pkg::param_t i_rd_data,
  // Parameter commands
  output logic                        o_wr_req,
  output logic [7:0]                  o_wr_offset,
  output param_bank_pkg::param_t      o_wr_data,
  output logic                        o_rd_req,
  output logic [7:0]                  o_rd_offset,
  output logic                        o_addr_commit
);
  import param_bank_pkg::*;

  // ****************************************
  // Idle state
  // ****************************************
  initial begin
    o_wr_req      = 1'b0;
    o_wr_offset   = 8'h00;
    o_wr_data     = 8'h00;
    o_rd_req      = 1'b0;
    o_rd_offset   = 8'h00;
    o_addr_commit = 1'b0;
  end

  // ****************************************
  // Commands
  // ****************************************
  // Released lines show the inverse, so stale values never pass for live
  task automatic write_param(input logic [7:0] ofs, input param_t data);
    @(negedge i_mclk);
    o_wr_req    = 1'b1;
    o_wr_offset = ofs;
    o_wr_data   = data;
    @(negedge i_mclk);
    o_wr_req    = 1'b0;
    o_wr_offset = ~ofs;
    o_wr_data   = ~data;
  endtask

  task automatic read_param(input logic [7:0] ofs, output param_t data,
                            output logic valid);
    @(negedge i_mclk);
    o_rd_req    = 1'b1;
    o_rd_offset = ofs;
    @(negedge i_mclk);
    o_rd_req    = 1'b0;
    o_rd_offset = ~ofs;
    valid       = i_rd_valid;
    data        = i_rd_data;
  endtask

  task automatic commit();
    @(negedge i_mclk);
    o_addr_commit = 1'b1;
    @(negedge i_mclk);
    o_addr_commit = 1'b0;
  endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import param_bank_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  typedef struct {logic [7:0] ofs; param_t wr; param_t exp;} row_s;
  logic             mclk, srst, wr_req, rd_req, rd_valid, addr_commit;
  logic             meas_active, list_empty, conv_valid, v;
  logic [7:0]       wr_offset, rd_offset;
  param_t           wr_data, rd_data, bus_addr, chan_list, rd;
  param_t           history, adc_ofs, emit_rec, ir_count, ir_gain, ir_misc;
  chan_e            meas_chan, conv_chan;
  logic [2:0]       emitter_drive;
  logic [16:0]      conv_data, d;
  logic [5:0][15:0] result;
  result_t          last_res [6];
  int               err_total, check_count, cyc;
  row_s rows [14] = '{'{8'h00,8'hff,8'hff}, '{8'h01,8'hff,8'h77},
    '{8'h02,8'hff,8'h77}, '{8'h03,8'hff,8'h07}, '{8'h05,8'hff,8'h70},
    '{8'h19,8'ha5,8'ha5}, '{8'h1a,8'h5a,8'h5a}, '{8'h1c,8'h3c,8'h3c},
    '{8'h1d,8'hff,8'h70}, '{8'h1e,8'hff,8'h07}, '{8'h1f,8'hff,8'h20},
    '{8'h04,8'hff,8'h00}, '{8'h0a,8'hff,8'h00}, '{8'h20,8'hff,8'h00}};
  row_s rst_rows [7] = '{'{8'h00,8'h0,8'h00}, '{8'h01,8'h0,8'h00},
    '{8'h02,8'h0,8'h21}, '{8'h03,8'h0,8'h04}, '{8'h05,8'h0,8'h00},
    '{8'h1b,8'h0,8'h00}, '{8'h1d,8'h0,8'h00}};

  // ****************************************
  // Instances
  // ****************************************
  param_bank dut_u (.i_mclk(mclk), .i_srst(srst), .i_wr_req(wr_req),
    .i_wr_offset(wr_offset), .i_wr_data(wr_data), .i_rd_req(rd_req),
    .i_rd_offset(rd_offset), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .i_addr_commit(addr_commit), .o_bus_addr(bus_addr),
    .i_meas_active(meas_active), .i_meas_chan(meas_chan),
    .o_emitter_drive(emitter_drive), .o_chan_list(chan_list),
    .o_list_empty(list_empty), .i_conv_valid(conv_valid),
    .i_conv_chan(conv_chan), .i_conv_data(conv_data), .o_result(result),
    .o_history(history), .o_adc_offset(adc_ofs), .o_emit_rec(emit_rec),
    .o_ir_count(ir_count), .o_ir_gain(ir_gain), .o_ir_misc(ir_misc));
  host_model host_u (.i_mclk(mclk), .i_rd_valid(rd_valid),
    .i_rd_data(rd_data), .o_wr_req(wr_req), .o_wr_offset(wr_offset),
    .o_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_offset(rd_offset),
    .o_addr_commit(addr_commit));

  // ****************************************
  // Clock, timeout and checks
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Ceiling well above the roughly 175 cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic fail(input string m);
    err_total++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask
  task automatic chk8(input param_t g, input param_t e);
    check_count++;
    if (g !== e) fail($sformatf("byte %h expected %h", g, e));
  endtask
  task automatic chk16(input result_t g, input result_t e);
    check_count++;
    if (g !== e) fail($sformatf("result %h expected %h", g, e));
  endtask
  task automatic chk3(input logic [2:0] g, input logic [2:0] e);
    check_count++;
    if (g !== e) fail($sformatf("emitters %b expected %b", g, e));
  endtask
  task automatic rd_chk(input logic [7:0] ofs, input param_t e);
    host_u.read_param(ofs, rd, v);
    chk8({7'h00, v}, 8'h01);
    chk8(rd, e);
  endtask
  task automatic emit(input logic act, input chan_e ch, input logic [2:0] e);
    @(negedge mclk);
    meas_active = act;
    meas_chan   = ch;
    @(negedge mclk);
    chk3(emitter_drive, e);
  endtask
  task automatic conv(input chan_e ch, input logic [16:0] dv,
                      input result_t e);
    @(negedge mclk);
    conv_valid = 1'b1;
    conv_chan  = ch;
    conv_data  = dv;
    @(negedge mclk);
    conv_valid = 1'b0;
    conv_data  = ~dv;
    chk16(result[ch], e);
  endtask
  task automatic do_reset();
    @(negedge mclk);
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    err_total = 0; check_count = 0; cyc = 0; srst = 1'b1;
    meas_active = 1'b0; meas_chan = CH_PS1; conv_valid = 1'b0;
    conv_chan = CH_PS1; conv_data = 17'h0;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    // Rows never write 0x1b, so it keeps its default
    foreach (rows[i]) begin
      host_u.write_param(rows[i].ofs, rows[i].wr);
      rd_chk(rows[i].ofs, rows[i].exp);
    end
    chk8(bus_addr, 8'h10);
    chk8(chan_list, 8'h77);
    chk8(history, 8'ha5);
    chk8(adc_ofs, 8'h5a);
    chk8(emit_rec, 8'h3c);
    chk8(ir_count, 8'h70);
    chk8(ir_gain, 8'h07);
    chk8(ir_misc, 8'h20);
    do_reset();
    chk8({7'h00, list_empty}, 8'h01);
    chk8(bus_addr, 8'h10);
    foreach (rst_rows[i]) rd_chk(rst_rows[i].ofs, rst_rows[i].exp);
    host_u.write_param(8'h00, 8'h5a);
    chk8(bus_addr, 8'h10);
    host_u.commit();
    chk8(bus_addr, 8'h5a);
    emit(1'b1, CH_PS1, 3'b001);
    emit(1'b1, CH_PS2, 3'b010);
    emit(1'b1, CH_PS3, 3'b100);
    host_u.write_param(8'h02, 8'h53);
    host_u.write_param(8'h03, 8'h06);
    emit(1'b1, CH_PS1, 3'b011);
    emit(1'b1, CH_PS2, 3'b101);
    emit(1'b1, CH_PS3, 3'b110);
    emit(1'b1, CH_VIS, 3'b000);
    emit(1'b1, CH_AUX, 3'b000);
    emit(1'b0, CH_PS2, 3'b000);
    host_u.write_param(8'h01, 8'h77);
    chk8({7'h00, list_empty}, 8'h00);
    // One alignment bit at a time exposes swapped bit positions
    for (int a = 0; a < 2; a++) begin
      for (int c = 0; c < 6; c++) begin
        host_u.write_param(8'h05, a ? (8'h10 << c) : 8'h00);
        d = {1'b1, 16'h5a00 + 16'(c * 16'h0101 + a)};
        last_res[c] = (a == 1 && c < 3) ? d[15:0] : d[16:1];
        conv(chan_e'(c), d, last_res[c]);
      end
    end
    for (int c = 0; c < 6; c++) begin
      host_u.write_param(8'h01, 8'h77 & ~(8'h01 << (c < 3 ? c : c + 1)));
      d = 17'h0f0f0 + 17'(c);
      conv(chan_e'(c), d, last_res[c]);
    end
    finish_test();
  end
endmodule
